// *** gce_pkg.sv ***
// shared constants for the buffer window and termination_byte_code link
package gce_pkg;
    localparam int ADDR_W          = 24;
    localparam int DATA_W          = 16;
    localparam int BYTE_W          = 8;
    localparam int RAM_AW          = 13;
    localparam int WIN_EN_BIT      = 15;
    localparam int HALF_BIT        = 15;
    localparam int BLK_LSB         = 16;
    localparam int OFS_MSB         = 14;
    localparam int CREG_LSB        = 1;
    localparam int CREG_W          = 3;
    // link register selects (device side)
    localparam logic [2:0] LSEL_MAP  = 3'h0;
    localparam logic [2:0] LSEL_TERM = 3'h1;
    localparam logic [2:0] LSEL_BRD  = 3'h2;
    localparam logic [2:0] LSEL_DIAG = 3'h3;
    localparam logic [2:0] LSEL_STAT = 3'h4;
    // board and diagnostic control bits
    localparam int BRD_RELEASE     = 0;
    localparam int BRD_LISTEN      = 1;
    localparam int DIAG_FORCE      = 0;
    // status bits
    localparam int ST_MATCH        = 0;
    localparam int ST_HOLD         = 1;
    localparam int ST_EOI          = 2;
    // apb register offsets of the host controller
    localparam logic [7:0] APB_CMD    = 8'h00;
    localparam logic [7:0] APB_WDATA  = 8'h04;
    localparam logic [7:0] APB_RDATA  = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0C;
    localparam logic [7:0] APB_IRQ    = 8'h10;
    localparam logic [7:0] APB_MASK   = 8'h14;
    // direction bit sits above the 24 address bits so it never aliases a select
    localparam int CMD_WRITE       = 24;
    localparam int IRQ_DONE        = 0;
    localparam int IRQ_MATCH       = 1;
    localparam int IRQ_W           = 2;
endpackage

// *** gce_if.sv ***
// link between host controller and buffer window / termination_byte_code device
`timescale 1ns/1ps
`default_nettype none
interface gce_if;
    import gce_pkg::*;
    logic              req;
    logic              wr;
    logic              space_ram;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              ack;
    logic              hit;
    logic              irq;
    modport host (output req, wr, space_ram, addr, wdata, input rdata, ack, hit, irq);
    modport dev  (input req, wr, space_ram, addr, wdata, output rdata, ack, hit, irq);
endinterface
`default_nettype wire

// *** gce_device.sv ***
// buffer window decode, buffer ram, controller regs and termination_byte_code detect
//
// Contract
// R1 - latch base byte, compare upper address byte
// R2 - enable bit in mapping word gates decode
// R3 - base match asserts window hit select
// R4 - hit only when half block bit zero
// R5 - buffer spans offsets 0000 to 3FFF only
// R6 - write strobe captures buffer write data
// R7 - controller registers selected by address bits 1-3
// R8 - detection only while listening
// R9 - eight bit code compared to bus byte
// R10 - software writes complemented code, bit 7 known
// R11 - match raises interrupt request
// R12 - match asserts not ready for data
// R13 - not ready held until release bit written
// R14 - transfer ends on eoi or match
// R15 - forced diagnostic byte sets readable match flag
// R16 - buffer disabled until mapping written
// R17 - host words, bus side single bytes
// R18 - simultaneous requests: bus controller first
// R19 - reset clears mapping enable
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gce_device
    import gce_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    gce_if.dev                     lnk,
    input  wire logic [BYTE_W-1:0] gpib_dio_n,
    input  wire logic              gpib_eoi_n,
    input  wire logic              gpib_byte_valid,
    input  wire logic              gpib_req,
    input  wire logic              gpib_wr,
    input  wire logic [OFS_MSB-1:0] gpib_addr,
    input  wire logic [BYTE_W-1:0] gpib_wdata,
    output logic [BYTE_W-1:0]      gpib_rdata,
    output logic                   gpib_ack,
    output logic                   nrfd_o,
    output logic                   nrfd_oe_n,
    output logic                   xfer_end
);
    logic [BYTE_W-1:0] base_q;
    logic              win_en_q;
    logic [BYTE_W-1:0] term_q;
    logic              listen_q;
    logic              force_q;
    logic              match_q;
    logic              hold_q;
    logic              eoi_q;
    logic [BYTE_W-1:0] ram_lo [1<<RAM_AW];
    logic [BYTE_W-1:0] ram_hi [1<<RAM_AW];
    logic [2:0]        dio_s0, dio_s1, dio_s2;
    logic [BYTE_W-1:0] d0_q, d1_q, d2_q;
    logic [BYTE_W-1:0] bus_byte;
    logic              hit, reg_acc, host_go, gpib_go, grant_gpib_q, host_wait_q;
    logic              cmp_eq, rel_wr;
    logic [CREG_W-1:0] sel;

    // R1 upper byte compare
    // R3 window hit select
    // R4 half block gate
    // R5 offset range check
    assign hit = win_en_q && (lnk.addr[ADDR_W-1:BLK_LSB] == base_q) && !lnk.addr[HALF_BIT]
                 && !lnk.addr[OFS_MSB];
    // R7 register select bits
    assign sel     = lnk.addr[CREG_LSB +: CREG_W];
    assign reg_acc = lnk.req && !lnk.space_ram;
    // R18 bus controller priority
    assign gpib_go = gpib_req && !(host_wait_q && !grant_gpib_q && lnk.req && lnk.space_ram);
    assign host_go = lnk.req && lnk.space_ram && !gpib_go && !lnk.ack;
    assign rel_wr  = reg_acc && lnk.wr && (sel == LSEL_BRD) && !lnk.ack;

    // arbiter memory: earlier host request keeps its turn
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            host_wait_q  <= 1'b0;
            grant_gpib_q <= 1'b0;
        end else begin
            host_wait_q  <= lnk.req && lnk.space_ram && !lnk.ack;
            grant_gpib_q <= gpib_go;
        end
    end

    // R16 mapping register
    // R19 enable cleared at reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            base_q   <= '0;
            win_en_q <= 1'b0;
        end else if (reg_acc && lnk.wr && sel == LSEL_MAP && !lnk.ack) begin
            // R2 enable bit capture
            base_q   <= lnk.wdata[BYTE_W-1:0];
            win_en_q <= lnk.wdata[WIN_EN_BIT];
        end
    end

    // termination, board and diagnostic registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            term_q   <= '0;
            listen_q <= 1'b0;
            force_q  <= 1'b0;
        end else if (reg_acc && lnk.wr && !lnk.ack) begin
            // R9 code capture
            // R10 complemented code stored as written
            if (sel == LSEL_TERM) term_q <= lnk.wdata[BYTE_W-1:0];
            if (sel == LSEL_BRD) listen_q <= lnk.wdata[BRD_LISTEN];
            if (sel == LSEL_DIAG) force_q <= lnk.wdata[DIAG_FORCE];
        end
    end

    // three stage pin synchroniser, change accepted when last two agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            d0_q <= '1;
            d1_q <= '1;
            d2_q <= '1;
            // idle levels: byte valid low, eoi released high
            dio_s0 <= 3'h2;
            dio_s1 <= 3'h2;
            dio_s2 <= 3'h2;
        end else begin
            d0_q <= gpib_dio_n;
            d1_q <= d0_q;
            d2_q <= d1_q;
            dio_s0 <= {gpib_byte_valid, gpib_eoi_n, 1'b0};
            dio_s1 <= dio_s0;
            dio_s2 <= dio_s1;
        end
    end
    assign bus_byte = (d1_q == d2_q) ? d2_q : term_q ^ 8'hFF;
    // R15 diagnostic forcing makes the compare true whatever the bus byte
    // R9 full byte compare
    assign cmp_eq = force_q ? 1'b1 : (bus_byte == term_q);

    // match, hold and eoi flags; set wins over release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            match_q <= 1'b0;
            hold_q  <= 1'b0;
            eoi_q   <= 1'b0;
        end else begin
            // R8 listener only
            // R12 match asserts hold
            if (listen_q && dio_s2[2] && dio_s1[2] && cmp_eq) begin
                match_q <= 1'b1;
                hold_q  <= 1'b1;
            // R13 release clears hold
            end else if (rel_wr && lnk.wdata[BRD_RELEASE]) begin
                match_q <= 1'b0;
                hold_q  <= 1'b0;
            end
            // R14 eoi end marker
            if (listen_q && dio_s2[2] && dio_s1[2] && !dio_s2[1] && !dio_s1[1]) eoi_q <= 1'b1;
            else if (rel_wr && lnk.wdata[BRD_RELEASE]) eoi_q <= 1'b0;
        end
    end

    // outputs toward the bus and the host interrupt
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nrfd_o    <= 1'b1;
            nrfd_oe_n <= 1'b1;
            xfer_end  <= 1'b0;
            lnk.irq   <= 1'b0;
            lnk.hit   <= 1'b0;
        end else begin
            nrfd_o    <= 1'b0;
            nrfd_oe_n <= !hold_q;
            xfer_end  <= hold_q || eoi_q;
            // R11 interrupt request
            lnk.irq   <= match_q;
            lnk.hit   <= lnk.req && lnk.space_ram && hit;
        end
    end

    // R17 word wide host port and byte wide bus port
    // R6 write strobe into ram
    always_ff @(posedge mclk) begin
        if (host_go && hit && lnk.wr) begin
            ram_lo[lnk.addr[RAM_AW:1]] <= lnk.wdata[BYTE_W-1:0];
            ram_hi[lnk.addr[RAM_AW:1]] <= lnk.wdata[DATA_W-1:BYTE_W];
        end else if (gpib_go && gpib_wr) begin
            if (gpib_addr[0]) ram_hi[gpib_addr[RAM_AW:1]] <= gpib_wdata;
            else ram_lo[gpib_addr[RAM_AW:1]] <= gpib_wdata;
        end
    end

    // host answers: one cycle after request, ram cycles later while the bus side is granted; unmapped reads as zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lnk.ack    <= 1'b0;
            lnk.rdata  <= '0;
            gpib_ack   <= 1'b0;
            gpib_rdata <= '0;
        end else begin
            lnk.ack  <= host_go || (reg_acc && !lnk.ack);
            gpib_ack <= gpib_go && !gpib_ack;
            if (host_go) begin
                lnk.rdata <= hit ? {ram_hi[lnk.addr[RAM_AW:1]], ram_lo[lnk.addr[RAM_AW:1]]} : '0;
            end else if (reg_acc && !lnk.ack) begin
                lnk.rdata <= (sel == LSEL_STAT) ?
                    {13'h0000, eoi_q, hold_q, match_q} : '0;
            end
            if (gpib_go) begin
                gpib_rdata <= gpib_addr[0] ? ram_hi[gpib_addr[RAM_AW:1]] :
                                             ram_lo[gpib_addr[RAM_AW:1]];
            end
        end
    end
endmodule
`default_nettype wire

// *** gce_host.sv ***
// apb controlled host end issuing link cycles
`timescale 1ns/1ps
`default_nettype none
module gce_host
    import gce_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    gce_if.host              lnk,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    typedef enum logic [0:0] {GH_IDLE, GH_BUSY} gce_state_type;
    gce_state_type     st_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic [IRQ_W-1:0]  stat_q, mask_q;
    logic              acc, wr_acc, rd_acc, match_seen_q;

    assign acc    = psel && penable && pready;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;

    // apb answers with one wait state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) pready <= 1'b0;
        else pready <= psel && !penable ? 1'b0 : (psel && !pready);
    end

    // read mux
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && !pready) begin
            pslverr <= 1'b0;
            unique case (paddr)
                APB_WDATA:  prdata <= {16'h0000, wdata_q};
                APB_RDATA:  prdata <= {16'h0000, rdata_q};
                APB_STATUS: prdata <= {30'h0, lnk.hit, st_q == GH_BUSY};
                APB_IRQ:    prdata <= {30'h0, stat_q};
                APB_MASK:   prdata <= {30'h0, mask_q};
                default:    prdata <= '0;
            endcase
        end
    end

    // command issue and link cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q          <= GH_IDLE;
            wdata_q       <= '0;
            rdata_q       <= '0;
            lnk.req       <= 1'b0;
            lnk.wr        <= 1'b0;
            lnk.space_ram <= 1'b0;
            lnk.addr      <= '0;
            lnk.wdata     <= '0;
        end else begin
            if (wr_acc && paddr == APB_WDATA) wdata_q <= pwdata[DATA_W-1:0];
            unique case (st_q)
                GH_IDLE: begin
                    if (wr_acc && paddr == APB_CMD) begin
                        lnk.req       <= 1'b1;
                        lnk.wr        <= pwdata[CMD_WRITE];
                        lnk.space_ram <= pwdata[ADDR_W+BYTE_W-1];
                        lnk.addr      <= pwdata[ADDR_W-1:0];
                        lnk.wdata     <= wdata_q;
                        st_q          <= GH_BUSY;
                    end
                end
                GH_BUSY: begin
                    if (lnk.ack) begin
                        lnk.req <= 1'b0;
                        rdata_q <= lnk.rdata;
                        st_q    <= GH_IDLE;
                    end
                end
            endcase
        end
    end

    // sticky events, set wins over read clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q       <= '0;
            mask_q       <= '0;
            match_seen_q <= 1'b0;
            irq          <= 1'b0;
        end else begin
            match_seen_q <= lnk.irq;
            if (wr_acc && paddr == APB_MASK) mask_q <= pwdata[IRQ_W-1:0];
            stat_q <= (rd_acc && paddr == APB_IRQ ? '0 : stat_q)
                      | {lnk.irq && !match_seen_q, st_q == GH_BUSY && lnk.ack};
            irq    <= |(stat_q & mask_q);
        end
    end
endmodule
`default_nettype wire

// *** gce_link_monitor.sv ***
// link checker for window decode, answer timing and hold release
`timescale 1ns/1ps
`default_nettype none
module gce_link_monitor
    import gce_pkg::*;
(
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic              req,
    input wire logic              wr,
    input wire logic              space_ram,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              ack,
    input wire logic              hit,
    input wire logic              irq
);
    logic [DATA_W-1:0] map_q;
    logic              win;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // mapping word as written over the link
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            map_q <= '0;
        end else if (ack && wr && !space_ram && addr[CREG_LSB +: CREG_W] == LSEL_MAP) begin
            map_q <= wdata;
        end
    end
    // expected window hit for the present address
    assign win = map_q[WIN_EN_BIT] && addr[ADDR_W-1:BLK_LSB] == map_q[BYTE_W-1:0]
                 && !addr[HALF_BIT] && !addr[OFS_MSB];
    a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_ack_has_req: assert property ($rose(ack) |-> $past(req)) else $error("ack without request");
    a_req_drops: assert property (ack |=> !req) else $error("request held after ack");
    a_req_holds: assert property (req && !ack |=> $stable(addr) && $stable(wr))
        else $error("request changed before ack");
    a_hit_half_block: assert property (ack && space_ram && addr[HALF_BIT] |-> !hit)
        else $error("hit in upper half");
    a_hit_past_top: assert property (ack && space_ram && addr[OFS_MSB] |-> !hit)
        else $error("hit past buffer top");
    a_hit_window: assert property (ack && space_ram |-> hit == win)
        else $error("hit differs from window");
    a_miss_reads_zero: assert property (ack && space_ram && !wr && !win |-> rdata == '0)
        else $error("read outside window not zero");
    // match flag falls only on a board write
    a_irq_release: assert property ($fell(irq) |->
        $past(req && wr && !space_ram && addr[CREG_LSB +: CREG_W] == LSEL_BRD))
        else $error("match flag fell without board write");
endmodule
`default_nettype wire

// *** gpib_cache_map_eom_detect_tb.sv ***
// self-checking bench: apb host end joined to the window and detect end
`timescale 1ns/1ps
`default_nettype none
module gpib_cache_map_eom_detect_tb;
    import gce_pkg::*;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, dio_n, g_rdata, g_wd;
    logic [31:0] pwdata, prdata, r;
    logic        eoi_n, bv, g_req, g_wr, g_ack, nrfd_o, nrfd_oe_n, xfer_end, hit_seen;
    logic [13:0] g_addr;
    int          n_fail, total_checks;
    logic [23:0] ta [5] = '{24'h5A0010, 24'h5A3FF0, 24'h5A8010, 24'h5A4010, 24'h5B0010};
    logic [15:0] te [5] = '{16'h1234, 16'hABCD, 16'h0000, 16'h0000, 16'h0000};
    gce_if i_gce_if ();
    gce_host i_gce_host (.mclk(mclk), .reset_n(reset_n), .lnk(i_gce_if), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    gce_device i_gce_device (.mclk(mclk), .reset_n(reset_n), .lnk(i_gce_if), .gpib_dio_n(dio_n),
        .gpib_eoi_n(eoi_n), .gpib_byte_valid(bv), .gpib_req(g_req), .gpib_wr(g_wr),
        .gpib_addr(g_addr), .gpib_wdata(g_wd), .gpib_rdata(g_rdata), .gpib_ack(g_ack),
        .nrfd_o(nrfd_o), .nrfd_oe_n(nrfd_oe_n), .xfer_end(xfer_end));
    gce_link_monitor i_gce_link_monitor (.mclk(mclk), .reset_n(reset_n), .req(i_gce_if.req),
        .wr(i_gce_if.wr), .space_ram(i_gce_if.space_ram), .addr(i_gce_if.addr),
        .wdata(i_gce_if.wdata), .rdata(i_gce_if.rdata), .ack(i_gce_if.ack),
        .hit(i_gce_if.hit), .irq(i_gce_if.irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one link cycle ordered through the host registers
    task automatic lop(input logic w, input logic ram, input logic [23:0] a,
                       input logic [15:0] d, output logic [31:0] q);
        logic [31:0] s;
        apb(1'b1, APB_WDATA, {16'h0, d}, s);
        apb(1'b1, APB_CMD, {ram, 7'h0, a} | ({31'h0, w} << CMD_WRITE), s);
        do begin
            apb(1'b0, APB_STATUS, 32'h0, s);
        end while (s[0] !== 1'b0);
        hit_seen = s[1];
        apb(1'b0, APB_RDATA, 32'h0, q);
    endtask
    // one listener byte; lines return to pulled-up idle
    task automatic gbyte(input logic [7:0] v, input logic eoi);
        dio_n <= v;
        eoi_n <= !eoi;
        repeat (2) @(posedge mclk);
        bv <= 1'b1;
        repeat (4) @(posedge mclk);
        bv <= 1'b0;
        eoi_n <= 1'b1;
        dio_n <= 8'hFF;
        repeat (10) @(posedge mclk);
    endtask
    task automatic grd(input logic [13:0] a, input logic [7:0] e);
        g_req <= 1'b1;
        g_addr <= a;
        do begin
            @(posedge mclk);
        end while (g_ack !== 1'b1);
        chk("bus byte", {24'h0, e}, {24'h0, g_rdata});
        g_req <= 1'b0;
        @(posedge mclk);
    endtask
    // one byte written from the bus controller side
    task automatic gwr(input logic [13:0] a, input logic [7:0] v);
        g_req <= 1'b1;
        g_wr <= 1'b1;
        g_addr <= a;
        g_wd <= v;
        do begin
            @(posedge mclk);
        end while (g_ack !== 1'b1);
        g_req <= 1'b0;
        g_wr <= 1'b0;
        @(posedge mclk);
    endtask
    // free running clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // bounds a hung run
    initial begin
        #1ms;
        n_fail++;
        print_verdict();
    end
    initial begin
        {reset_n, psel, penable, pwrite, bv, g_req, g_wr} = '0;
        {paddr, pwdata, g_addr, g_wd} = '0;
        dio_n = 8'hFF;
        eoi_n = 1'b1;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        apb(1'b1, APB_MASK, 32'h2, r);
        lop(1'b1, 1'b1, 24'h000010, 16'h1111, r);
        lop(1'b0, 1'b1, 24'h000010, 16'h0, r);
        chk("ram unmapped", 32'h0, r);
        chk1("hit unmapped", 1'b0, hit_seen);
        apb(1'b0, APB_IRQ, 32'h0, r);
        chk("done flag", 32'h1, r & 32'h1);
        lop(1'b1, 1'b0, 24'h0, 16'h805A, r);
        lop(1'b1, 1'b1, 24'h5A0010, 16'h1234, r);
        lop(1'b1, 1'b1, 24'h5A3FF0, 16'hABCD, r);
        lop(1'b1, 1'b1, 24'h5A4010, 16'h9999, r);
        for (int i = 0; i < 5; i++) begin
            lop(1'b0, 1'b1, ta[i], 16'h0, r);
            chk("window read", {16'h0, te[i]}, r);
            chk1("window hit", te[i] != 16'h0, hit_seen);
        end
        grd(14'h0010, 8'h34);
        grd(14'h0011, 8'h12);
        gwr(14'h0012, 8'h77);
        gwr(14'h0013, 8'h66);
        lop(1'b0, 1'b1, 24'h5A0012, 16'h0, r);
        chk("bus bytes as word", 32'h6677, r);
        lop(1'b1, 1'b0, 24'h0, 16'h005A, r);
        lop(1'b0, 1'b1, 24'h5A0010, 16'h0, r);
        chk("ram disabled", 32'h0, r);
        lop(1'b1, 1'b0, 24'h2, 16'h00C5, r);
        lop(1'b1, 1'b0, 24'h4, 16'h0002, r);
        apb(1'b1, APB_MASK, 32'h0, r);
        gbyte(8'hC4, 1'b0);
        chk1("no match nrfd", 1'b1, nrfd_oe_n);
        gbyte(8'hC5, 1'b0);
        chk1("nrfd held", 1'b0, nrfd_oe_n);
        chk1("transfer end", 1'b1, xfer_end);
        chk1("match request", 1'b1, i_gce_if.irq);
        chk1("masked irq", 1'b0, irq);
        apb(1'b1, APB_MASK, 32'h2, r);
        repeat (2) @(posedge mclk);
        chk1("unmasked irq", 1'b1, irq);
        apb(1'b0, APB_IRQ, 32'h0, r);
        chk("match status", 32'h2, r & 32'h2);
        lop(1'b1, 1'b0, 24'h4, 16'h0003, r);
        chk1("nrfd released", 1'b1, nrfd_oe_n);
        chk1("match cleared", 1'b0, i_gce_if.irq);
        lop(1'b1, 1'b0, 24'h4, 16'h0000, r);
        gbyte(8'hC5, 1'b0);
        chk1("not listening", 1'b1, nrfd_oe_n);
        lop(1'b1, 1'b0, 24'h6, 16'h0001, r);
        lop(1'b1, 1'b0, 24'h4, 16'h0002, r);
        gbyte(8'h00, 1'b0);
        chk1("forced match", 1'b1, i_gce_if.irq);
        lop(1'b0, 1'b0, 24'h8, 16'h0, r);
        chk("match flag read", 32'h3, r);
        lop(1'b1, 1'b0, 24'h4, 16'h0003, r);
        lop(1'b1, 1'b0, 24'h6, 16'h0000, r);
        gbyte(8'h00, 1'b1);
        chk1("eoi end", 1'b1, xfer_end);
        chk1("eoi no hold", 1'b1, nrfd_oe_n);
        apb(1'b0, 8'h40, 32'h0, r);
        chk("unmapped apb", 32'h0, r);
        print_verdict();
    end
endmodule
`default_nettype wire
